// ==== core/arb_cfg_pkg.sv ====
// Shared constants for the port arbitration table and power budget header bank.
// Assumes an APB slave with a 12-bit byte address and 32-bit data on one clock.
package arb_cfg_pkg;

  // ----------------------------------------------------------------------
  // Bus and table geometry
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int PORT_ID_W = 4;
  localparam int PHASE_W = 5;
  localparam int PHASE_COUNT = 32;
  localparam int TABLE_W = PHASE_COUNT * PORT_ID_W;
  localparam int WORD0_LSB = 0;
  localparam int WORD1_LSB = 32;
  localparam int WORD2_LSB = 64;
  localparam int WORD3_LSB = 96;

  // ----------------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_TBL_8_15 = 12'h224;
  localparam logic [ADDR_W-1:0] OFF_TBL_16_23 = 12'h228;
  localparam logic [ADDR_W-1:0] OFF_TBL_24_31 = 12'h22C;
  localparam logic [ADDR_W-1:0] OFF_CAP_HDR = 12'h280;
  localparam logic [ADDR_W-1:0] OFF_TBL_CTRL = 12'h2F0;
  localparam logic [ADDR_W-1:0] OFF_TBL_STAT = 12'h2F4;

  // ----------------------------------------------------------------------
  // Reset values, phase N in nibble (N mod 8)
  // ----------------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_TBL_0_7 = 32'h17654321;
  localparam logic [DATA_W-1:0] RST_TBL_8_15 = 32'h21765432;
  localparam logic [DATA_W-1:0] RST_TBL_16_23 = 32'h32176543;
  localparam logic [DATA_W-1:0] RST_TBL_24_31 = 32'h43217654;
  localparam logic [DATA_W-1:0] RST_CAP_HDR = 32'h00000000;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h00000000;

  // ----------------------------------------------------------------------
  // Capability header fields
  // ----------------------------------------------------------------------
  localparam int CAP_ID_LSB = 0;
  localparam int CAP_ID_MSB = 15;
  localparam int CAP_VER_LSB = 16;
  localparam int CAP_VER_MSB = 19;
  localparam int CAP_NEXT_LSB = 20;
  localparam int CAP_NEXT_MSB = 31;
  localparam logic [15:0] CAP_ID_POWER_BUDGET = 16'h0004;
  localparam logic [3:0] CAP_VER_ONE = 4'h1;

  // ----------------------------------------------------------------------
  // Control and status bits
  // ----------------------------------------------------------------------
  localparam int CTRL_UNLOCK_BIT = 0;
  localparam int CTRL_LOAD_BIT = 1;
  localparam int STAT_COHERENCY_BIT = 0;

  // ----------------------------------------------------------------------
  // Port identifier encoding
  // ----------------------------------------------------------------------
  localparam logic [PORT_ID_W-1:0] PORT_UPSTREAM = 4'h0;
  localparam logic [PORT_ID_W-1:0] PORT_DOWN_2 = 4'h2;
  localparam logic [PORT_ID_W-1:0] PORT_DOWN_3 = 4'h3;
  localparam logic [PORT_ID_W-1:0] EGRESS_DEFAULT = 4'h2;

  // Table load sequencer states.
  typedef enum logic [1:0] {
    load_idle,
    load_copy,
    load_done
  } load_state_t;

endpackage

// ==== core/phase_word.sv ====
// One 32-bit word of eight 4-bit phase fields with its own reset pattern.
// Assumes the write strobe is already qualified by the bus decode.
`timescale 1ns/1ns
module phase_word #(
  parameter logic [31:0] reset_value = 32'h00000000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic write_en,
  input wire logic [31:0] write_data,
  output logic [31:0] word_r
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------

  // The word loads its reset pattern and takes any full-word write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_r <= reset_value;
    end else if (write_en) begin
      word_r <= write_data;
    end
  end

endmodule

// ==== core/phase_search.sv ====
// Combinational search for the next phase that names a serviceable port.
// Assumes the table is packed with phase N at bits 4N+3 down to 4N.
`timescale 1ns/1ns
module phase_search (
  input wire logic [arb_cfg_pkg::TABLE_W-1:0] table_bits,
  input wire logic [arb_cfg_pkg::PHASE_W-1:0] cur_phase,
  input wire logic [arb_cfg_pkg::PORT_ID_W-1:0] egress_id,
  output logic [arb_cfg_pkg::PHASE_W-1:0] next_phase,
  output logic [arb_cfg_pkg::PORT_ID_W-1:0] next_port,
  output logic found
);

  // ----------------------------------------------------------------------
  // Search
  // ----------------------------------------------------------------------

  // A port number is usable when it is encoded and is not the egress port.
  function automatic logic id_usable(input logic [arb_cfg_pkg::PORT_ID_W-1:0] id,
                                     input logic [arb_cfg_pkg::PORT_ID_W-1:0] own);
    logic known;
    known = (id == arb_cfg_pkg::PORT_UPSTREAM) || (id == arb_cfg_pkg::PORT_DOWN_2) ||
            (id == arb_cfg_pkg::PORT_DOWN_3);
    return known && (id != own);
  endfunction

  // Walk forward from the phase after the current one, wrapping at the end,
  // and stop at the first usable entry so that bad entries cost no time.
  always_comb begin
    logic [arb_cfg_pkg::PHASE_W-1:0] idx;
    logic [arb_cfg_pkg::PORT_ID_W-1:0] id;
    idx = cur_phase;
    id = arb_cfg_pkg::PORT_UPSTREAM;
    next_phase = cur_phase;
    next_port = arb_cfg_pkg::PORT_UPSTREAM;
    found = 1'b0;
    for (int i = 1; i <= arb_cfg_pkg::PHASE_COUNT; i++) begin
      idx = cur_phase + i[arb_cfg_pkg::PHASE_W-1:0];
      id = table_bits[idx*arb_cfg_pkg::PORT_ID_W +: arb_cfg_pkg::PORT_ID_W];
      if (!found && id_usable(id, egress_id)) begin
        found = 1'b1;
        next_phase = idx;
        next_port = id;
      end
    end
  end

endmodule

// ==== core/port_arb_table_and_power_budget_hdr.sv ====
// Register bank for table words two to four of the port arbitration table and
// the power budget capability header, with the egress arbiter that uses them.
// Assumes an APB master on pclk, the first table word supplied from outside on
// the same clock, and a one-cycle period tick from the link scheduler.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns

// Overview of operation
// - Word 0x224 holds phases 8-15, low first.
// - Word 0x228 holds phases 16-23, low first.
// - Word 0x22C holds phases 24-31, low first.
// - Each phase names the ingress port served.
// - Phases 8-15 reset to 2,3,4,5,6,7,1,2.
// - Phases 16-23 reset to 3,4,5,6,7,1,2,3.
// - Phases 24-31 reset to 4,5,6,7,1,2,3,4.
// - Header bits 15:0 hold structure identifier.
// - Header bits 19:16 hold structure version.
// - Header resets zero, writable only when unlocked.
// - Invalid port phases are skipped without delay.
// - Encoding 0 upstream, 2 and 3 downstream.
// - Table write sets flag; load clears it.
module port_arb_table_and_power_budget_hdr #(
  parameter logic [arb_cfg_pkg::PORT_ID_W-1:0] egress_port_id = arb_cfg_pkg::EGRESS_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [arb_cfg_pkg::ADDR_W-1:0] paddr,
  input wire logic [arb_cfg_pkg::DATA_W-1:0] pwdata,
  output logic [arb_cfg_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [arb_cfg_pkg::DATA_W-1:0] table_word0,
  input wire logic table_word0_written,
  input wire logic period_tick,
  output logic [arb_cfg_pkg::PHASE_W-1:0] active_phase_r,
  output logic [arb_cfg_pkg::PORT_ID_W-1:0] granted_port_r,
  output logic grant_valid_r,
  output logic table_coherency_flag_r,
  output logic [15:0] structure_identifier_r,
  output logic [3:0] structure_version_r,
  output logic [11:0] following_structure_offset_r,
  output logic power_budget_header_r
);

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------

  logic pready_r;
  logic pslverr_r;
  logic [arb_cfg_pkg::DATA_W-1:0] prdata_r;
  logic [arb_cfg_pkg::DATA_W-1:0] tbl_8_15;
  logic [arb_cfg_pkg::DATA_W-1:0] tbl_16_23;
  logic [arb_cfg_pkg::DATA_W-1:0] tbl_24_31;
  logic [arb_cfg_pkg::DATA_W-1:0] cap_hdr_r;
  logic lockable_write_access_r;
  logic table_load_request_r;

  // The access phase lasts two cycles; the write lands on the edge that
  // completes it, when pready is seen high.
  wire access_phase = psel && penable;
  wire access_done = access_phase && pready_r;
  wire wr_done = access_done && pwrite;
  wire sel_tbl_8_15 = (paddr == arb_cfg_pkg::OFF_TBL_8_15);
  wire sel_tbl_16_23 = (paddr == arb_cfg_pkg::OFF_TBL_16_23);
  wire sel_tbl_24_31 = (paddr == arb_cfg_pkg::OFF_TBL_24_31);
  wire sel_cap_hdr = (paddr == arb_cfg_pkg::OFF_CAP_HDR);
  wire sel_ctrl = (paddr == arb_cfg_pkg::OFF_TBL_CTRL);
  wire sel_stat = (paddr == arb_cfg_pkg::OFF_TBL_STAT);
  wire sel_any = sel_tbl_8_15 || sel_tbl_16_23 || sel_tbl_24_31 || sel_cap_hdr ||
                 sel_ctrl || sel_stat;

  // Per-register write strobes.
  wire we_tbl_8_15 = wr_done && sel_tbl_8_15;
  wire we_tbl_16_23 = wr_done && sel_tbl_16_23;
  wire we_tbl_24_31 = wr_done && sel_tbl_24_31;
  wire we_cap_hdr = wr_done && sel_cap_hdr && lockable_write_access_r;
  wire we_ctrl = wr_done && sel_ctrl;

  // Control and status words as software sees them.
  wire [arb_cfg_pkg::DATA_W-1:0] ctrl_view =
    {{(arb_cfg_pkg::DATA_W-1){1'b0}}, lockable_write_access_r};
  wire [arb_cfg_pkg::DATA_W-1:0] stat_view =
    {{(arb_cfg_pkg::DATA_W-1){1'b0}}, table_coherency_flag_r};

  // Read multiplexer; unmapped addresses read as zero.
  wire [arb_cfg_pkg::DATA_W-1:0] rd_mux =
    sel_tbl_8_15 ? tbl_8_15 :
    sel_tbl_16_23 ? tbl_16_23 :
    sel_tbl_24_31 ? tbl_24_31 :
    sel_cap_hdr ? cap_hdr_r :
    sel_ctrl ? ctrl_view :
    sel_stat ? stat_view : arb_cfg_pkg::ZERO_WORD;

  // ----------------------------------------------------------------------
  // Bus response
  // ----------------------------------------------------------------------

  // Ready rises in the second access cycle and falls after the completing
  // edge, so the read data and error flag are stable while it is high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= arb_cfg_pkg::ZERO_WORD;
    end else begin
      pready_r <= access_phase && !pready_r;
      pslverr_r <= access_phase && !pready_r && !sel_any;
      prdata_r <= (access_phase && !pready_r && !pwrite) ? rd_mux : arb_cfg_pkg::ZERO_WORD;
    end
  end

  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;

  // ----------------------------------------------------------------------
  // Table words seen by software
  // ----------------------------------------------------------------------

  // Phases 8 to 15, phase 8 in the lowest nibble.
  phase_word #(
    .reset_value(arb_cfg_pkg::RST_TBL_8_15)
  ) u_word_8_15 (
    .pclk(pclk),
    .presetn(presetn),
    .write_en(we_tbl_8_15),
    .write_data(pwdata),
    .word_r(tbl_8_15)
  );

  // Phases 16 to 23, phase 16 in the lowest nibble.
  phase_word #(
    .reset_value(arb_cfg_pkg::RST_TBL_16_23)
  ) u_word_16_23 (
    .pclk(pclk),
    .presetn(presetn),
    .write_en(we_tbl_16_23),
    .write_data(pwdata),
    .word_r(tbl_16_23)
  );

  // Phases 24 to 31, phase 24 in the lowest nibble.
  phase_word #(
    .reset_value(arb_cfg_pkg::RST_TBL_24_31)
  ) u_word_24_31 (
    .pclk(pclk),
    .presetn(presetn),
    .write_en(we_tbl_24_31),
    .write_data(pwdata),
    .word_r(tbl_24_31)
  );

  // ----------------------------------------------------------------------
  // Capability header and control
  // ----------------------------------------------------------------------

  // The header is locked against ordinary writes; software opens it with the
  // unlock bit, normally only while the boot image is being applied.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_hdr_r <= arb_cfg_pkg::RST_CAP_HDR;
    end else if (we_cap_hdr) begin
      cap_hdr_r <= pwdata;
    end
  end

  // The unlock bit is stored; the load bit is a request pulse that reads zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lockable_write_access_r <= 1'b0;
      table_load_request_r <= 1'b0;
    end else begin
      if (we_ctrl) begin
        lockable_write_access_r <= pwdata[arb_cfg_pkg::CTRL_UNLOCK_BIT];
      end
      table_load_request_r <= we_ctrl && pwdata[arb_cfg_pkg::CTRL_LOAD_BIT];
    end
  end

  // Header fields mirrored onto ports, each straight from a flip-flop.
  wire [15:0] cap_id_nxt = cap_hdr_r[arb_cfg_pkg::CAP_ID_MSB:arb_cfg_pkg::CAP_ID_LSB];
  wire [3:0] cap_ver_nxt = cap_hdr_r[arb_cfg_pkg::CAP_VER_MSB:arb_cfg_pkg::CAP_VER_LSB];
  wire [11:0] cap_next_nxt = cap_hdr_r[arb_cfg_pkg::CAP_NEXT_MSB:arb_cfg_pkg::CAP_NEXT_LSB];
  wire cap_match_nxt = (cap_id_nxt == arb_cfg_pkg::CAP_ID_POWER_BUDGET) &&
                       (cap_ver_nxt == arb_cfg_pkg::CAP_VER_ONE);

  // These lag the header register by one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      structure_identifier_r <= 16'h0000;
      structure_version_r <= 4'h0;
      following_structure_offset_r <= 12'h000;
      power_budget_header_r <= 1'b0;
    end else begin
      structure_identifier_r <= cap_id_nxt;
      structure_version_r <= cap_ver_nxt;
      following_structure_offset_r <= cap_next_nxt;
      power_budget_header_r <= cap_match_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Table load sequencer and coherency flag
  // ----------------------------------------------------------------------

  arb_cfg_pkg::load_state_t load_state_r;
  arb_cfg_pkg::load_state_t load_state_nxt;
  logic [arb_cfg_pkg::TABLE_W-1:0] active_table_r;

  // Any write to a table word, here or in the first word outside, makes the
  // working copy stale.
  wire table_written = we_tbl_8_15 || we_tbl_16_23 || we_tbl_24_31 || table_word0_written;
  wire load_finish = (load_state_r == arb_cfg_pkg::load_done);
  wire [arb_cfg_pkg::TABLE_W-1:0] shadow_table =
    {tbl_24_31, tbl_16_23, tbl_8_15, table_word0};
  localparam logic [arb_cfg_pkg::TABLE_W-1:0] reset_table =
    {arb_cfg_pkg::RST_TBL_24_31, arb_cfg_pkg::RST_TBL_16_23,
     arb_cfg_pkg::RST_TBL_8_15, arb_cfg_pkg::RST_TBL_0_7};

  // A request copies the software table into the working copy, then the
  // sequencer reports completion one cycle later.
  always_comb begin
    load_state_nxt = load_state_r;
    unique case (load_state_r)
      arb_cfg_pkg::load_idle: begin
        if (table_load_request_r) begin
          load_state_nxt = arb_cfg_pkg::load_copy;
        end
      end
      arb_cfg_pkg::load_copy: begin
        load_state_nxt = arb_cfg_pkg::load_done;
      end
      arb_cfg_pkg::load_done: begin
        load_state_nxt = arb_cfg_pkg::load_idle;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_state_r <= arb_cfg_pkg::load_idle;
    end else begin
      load_state_r <= load_state_nxt;
    end
  end

  // Working copy used by the arbiter; it starts equal to the reset table.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_table_r <= reset_table;
    end else if (load_state_r == arb_cfg_pkg::load_copy) begin
      active_table_r <= shadow_table;
    end
  end

  // A write in the same cycle as the load completion keeps the flag set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_coherency_flag_r <= 1'b0;
    end else if (table_written) begin
      table_coherency_flag_r <= 1'b1;
    end else if (load_finish) begin
      table_coherency_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Egress arbiter
  // ----------------------------------------------------------------------

  logic [arb_cfg_pkg::PHASE_W-1:0] next_phase;
  logic [arb_cfg_pkg::PORT_ID_W-1:0] next_port;
  logic next_found;

  // Finds the next usable phase after the current one in a single cycle.
  phase_search u_search (
    .table_bits(active_table_r),
    .cur_phase(active_phase_r),
    .egress_id(egress_port_id),
    .next_phase(next_phase),
    .next_port(next_port),
    .found(next_found)
  );

  // On each period tick the arbiter moves to the next usable phase and
  // grants the port it names; with no usable entry the grant drops and the
  // phase steps by one so the walk still wraps.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_phase_r <= {arb_cfg_pkg::PHASE_W{1'b1}};
      granted_port_r <= arb_cfg_pkg::PORT_UPSTREAM;
      grant_valid_r <= 1'b0;
    end else if (period_tick) begin
      if (next_found) begin
        active_phase_r <= next_phase;
        granted_port_r <= next_port;
        grant_valid_r <= 1'b1;
      end else begin
        active_phase_r <= active_phase_r + 5'h01;
        granted_port_r <= arb_cfg_pkg::PORT_UPSTREAM;
        grant_valid_r <= 1'b0;
      end
    end
  end

endmodule

// ==== sim/arb_bank_checker.sv ====
// Concurrent checks on the arbitration table and capability header bank.
// Assumes it is bound into the bank top and sees only its ports.
`timescale 1ns/1ns
module arb_bank_checker #(
  parameter logic [3:0] egress_port_id = 4'h2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] table_word0,
  input wire logic table_word0_written,
  input wire logic period_tick,
  input wire logic [4:0] active_phase_r,
  input wire logic [3:0] granted_port_r,
  input wire logic grant_valid_r,
  input wire logic table_coherency_flag_r,
  input wire logic [15:0] structure_identifier_r,
  input wire logic [3:0] structure_version_r,
  input wire logic [11:0] following_structure_offset_r,
  input wire logic power_budget_header_r
);
  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Table words and the known bank offsets are mapped, all else errors.
  wire logic tbl_hit = paddr == 12'h224 || paddr == 12'h228 || paddr == 12'h22C;
  wire logic map_hit = tbl_hit || paddr == 12'h280 || paddr == 12'h2F0 || paddr == 12'h2F4;
  wire logic [31:0] hdr_view = {following_structure_offset_r, structure_version_r,
                                structure_identifier_r};

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_table_write;
    (pready && pwrite && tbl_hit) || table_word0_written;
  endsequence
  property p_ready_wait;
    s_setup |=> !pready ##1 pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("ready timing wrong");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
  property p_rdata_idle;
    !pready |-> prdata == 32'h00000000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_err_map;
    pready |-> pslverr == !map_hit;
  endproperty
  a_err_map: assert property (p_err_map) else $error("error flag wrong");
  property p_flag_set;
    s_table_write |=> table_coherency_flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");
  property p_hdr_change;
    !$stable(hdr_view) |-> $past(pready && pwrite && paddr == 12'h280, 2);
  endproperty
  a_hdr_change: assert property (p_hdr_change) else $error("header moved");
  property p_hdr_flag;
    power_budget_header_r == (structure_identifier_r == 16'h0004 &&
                              structure_version_r == 4'h1);
  endproperty
  a_hdr_flag: assert property (p_hdr_flag) else $error("header flag wrong");
  property p_phase_hold;
    !period_tick |=> $stable(active_phase_r);
  endproperty
  a_phase_hold: assert property (p_phase_hold) else $error("phase moved");
  property p_grant_id;
    grant_valid_r |-> granted_port_r != egress_port_id &&
      (granted_port_r == 4'h0 || granted_port_r == 4'h2 || granted_port_r == 4'h3);
  endproperty
  a_grant_id: assert property (p_grant_id) else $error("bad grant");
  property p_no_grant;
    !grant_valid_r |-> granted_port_r == 4'h0;
  endproperty
  a_no_grant: assert property (p_no_grant) else $error("stale port");
endmodule

bind port_arb_table_and_power_budget_hdr arb_bank_checker #(
  .egress_port_id(egress_port_id)
) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .table_word0(table_word0), .table_word0_written(table_word0_written),
  .period_tick(period_tick), .active_phase_r(active_phase_r),
  .granted_port_r(granted_port_r), .grant_valid_r(grant_valid_r),
  .table_coherency_flag_r(table_coherency_flag_r),
  .structure_identifier_r(structure_identifier_r), .structure_version_r(structure_version_r),
  .following_structure_offset_r(following_structure_offset_r),
  .power_budget_header_r(power_budget_header_r));

// ==== sim/tb.sv ====
// Self-checking bench for the arbitration table and capability header bank.
// Assumes the bank package is compiled first and the checker is bound in.
`timescale 1ns/1ns
module tb;
  localparam logic [3:0] EGR = 4'h3;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tw0_wr, tick;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, tw0, rd, w[3];
  logic [4:0] phase, cur;
  logic [3:0] port;
  logic valid, flag, hdr_ok, er;
  logic [15:0] sid;
  logic [3:0] sver;
  logic [11:0] soff;
  logic [127:0] tbl;
  logic [9:0] ex;
  int errors, n_tests;
  integer seed;

  port_arb_table_and_power_budget_hdr #(.egress_port_id(EGR)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .table_word0(tw0), .table_word0_written(tw0_wr), .period_tick(tick),
    .active_phase_r(phase), .granted_port_r(port), .grant_valid_r(valid),
    .table_coherency_flag_r(flag), .structure_identifier_r(sid),
    .structure_version_r(sver), .following_structure_offset_r(soff),
    .power_budget_header_r(hdr_ok));

  // Free-running bus clock.
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ----------------------------------------------------------------------
  // Tasks and expectation model
  // ----------------------------------------------------------------------
  // Next usable phase after cur, as {valid, port, phase}.
  function automatic logic [9:0] arb_next(input logic [127:0] t, input logic [4:0] c);
    logic [4:0] p;
    logic [3:0] id;
    for (int i = 1; i <= 32; i++) begin
      p = c + 5'(i);
      id = t[p*4 +: 4];
      if ((id == 4'h0 || id == 4'h2 || id == 4'h3) && id != EGR) return {1'b1, id, p};
    end
    return {1'b0, 4'h0, c + 5'h01};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      errors++;
      give_verdict();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
    apb(1'b0, a, 32'h00000000);
    chk(rd, exp);
    chk({31'h00000000, er}, {31'h00000000, eerr});
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  // Reset, register defaults, refusals, header unlock, then load and arbitrate.
  initial begin
    seed = 32'h4F4E2C9A;
    {psel, penable, pwrite, tw0_wr, tick} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    tw0 = 32'h00000000;
    presetn = 1'b0;
    errors = 0;
    n_tests = 0;
    cur = 5'h1F;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(12'h224, 32'h21765432, 1'b0);
    rd_chk(12'h228, 32'h32176543, 1'b0);
    rd_chk(12'h22C, 32'h43217654, 1'b0);
    rd_chk(12'h280, 32'h00000000, 1'b0);
    rd_chk(12'h2F4, 32'h00000000, 1'b0);
    rd_chk(12'h300, 32'h00000000, 1'b1);
    apb(1'b1, 12'h230, $random(seed));
    chk({31'h00000000, er}, 32'h00000001);
    apb(1'b1, 12'h280, 32'h00110004);
    rd_chk(12'h280, 32'h00000000, 1'b0);
    apb(1'b1, 12'h2F0, 32'h00000001);
    apb(1'b1, 12'h280, 32'hABC10004);
    rd_chk(12'h280, 32'hABC10004, 1'b0);
    #1;
    chk({soff, sver, sid}, 32'hABC10004);
    chk({31'h00000000, hdr_ok}, 32'h00000001);
    @(posedge pclk);
    tw0_wr <= 1'b1;
    @(posedge pclk);
    tw0_wr <= 1'b0;
    rd_chk(12'h2F4, 32'h00000001, 1'b0);
    for (int r = 0; r < 4; r++) begin
      tw0 <= (r == 0) ? 32'h11111111 : $random(seed);
      for (int k = 0; k < 3; k++) begin
        w[k] = (r == 0) ? 32'h11111111 : $random(seed);
        apb(1'b1, 12'h224 + 12'(4 * k), w[k]);
        rd_chk(12'h224 + 12'(4 * k), w[k], 1'b0);
      end
      rd_chk(12'h2F4, 32'h00000001, 1'b0);
      apb(1'b1, 12'h2F0, 32'h00000003);
      repeat (3) @(posedge pclk);
      rd_chk(12'h2F4, 32'h00000000, 1'b0);
      tbl = {w[2], w[1], w[0], tw0};
      for (int k = 0; k < 6; k++) begin
        @(posedge pclk);
        tick <= 1'b1;
        @(posedge pclk);
        tick <= 1'b0;
        #1;
        ex = arb_next(tbl, cur);
        cur = ex[4:0];
        chk(32'({valid, port, phase}), 32'(ex));
      end
    end
    give_verdict();
  end
endmodule
